//--- sbac_top.sv
// sbac_top: burst read and write engine of a synchronous dram, seen from its pins
module sbac_top
	import sbac_pkg::*;
#(
	parameter int FIFO_DEPTH = SBAC_FIFO_DEPTH
) (
	input  wire logic                 clk_sys,
	input  wire logic                 rst_n,
	input  wire sbac_pins_s           pins,
	input  wire logic    [DATA_W-1:0] dqIn,
	input  wire logic           [2:0] burstLenCode,
	input  wire logic                 interleaved,
	input  wire logic           [1:0] casLatency,
	output logic         [DATA_W-1:0] dqOut,
	output logic                      dqOe,
	output logic      [NUM_BANKS-1:0] bankOpen,
	output logic                      selfRefresh,
	output logic                      bufReady
);

	sbac_state_s      s_q;
	sbac_state_s      s_d;
	sbac_cmd_e        cmd;
	logic [COL_W-1:0] last;
	logic [COL_W-1:0] clm1;
	logic             rdEmit;
	logic [COL_W-1:0] rdCol;
	logic [COL_W-1:0] rdCurK;
	logic             rdCurAp;
	logic [BANK_W-1:0] rdCurBk;
	logic             wrWord;
	logic [COL_W-1:0] wrCurK;
	logic             wrCurAp;
	logic [BANK_W-1:0] wrCurBk;
	logic [COL_W-1:0] wrStartNow;
	logic             pushValid;
	sbac_wr_s         pushData;
	logic             pushReady;
	logic             popValid;
	sbac_wr_s         popData;
	logic             popReady;
	logic             pipeSel;

	if (FIFO_DEPTH < 2) begin : g_chk
		$error("sbac_top write buffer depth too small");
	end

	// accepted write words wait here until the array is free of read traffic
	sbac_fifo #(
		.WIDTH ($bits(sbac_wr_s)),
		.DEPTH (FIFO_DEPTH)
	) u_wbuf (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.inValid  (pushValid),
		.inData   (pushData),
		.inReady  (pushReady),
		.outValid (popValid),
		.outData  (popData),
		.outReady (popReady)
	);

	// command handling, burst generators, read pipeline and array update
	always_comb begin
		s_d        = s_q;
		cmd        = sbac_decode(pins);
		last       = sbac_len_last(burstLenCode);
		// any latency code other than two behaves as three, so the lead follows the same split
		clm1       = (casLatency != CL_TWO) ? COL_W'(CL_TWO) : COL_W'(CL_TWO - 2'h1);
		rdEmit     = 1'b0;
		rdCol      = '0;
		rdCurK     = '0;
		rdCurAp    = 1'b0;
		rdCurBk    = '0;
		wrWord     = 1'b0;
		wrCurK     = '0;
		wrCurAp    = 1'b0;
		wrCurBk    = '0;
		wrStartNow = '0;
		pushValid  = 1'b0;
		pushData   = '0;
		popReady   = 1'b0;
		pipeSel    = (casLatency != CL_TWO);

		if (s_q.selfRef) begin
			cmd = CMD_NOP;
			if (pins.cke) begin
				s_d.selfRef = 1'b0;
			end
		end

		if (s_q.wrApPend) begin
			if (s_q.wrApCnt == 2'h0) begin
				s_d.bankOpen[s_q.wrApBank] = 1'b0;
				s_d.wrApPend               = 1'b0;
			end else begin
				s_d.wrApCnt = s_q.wrApCnt - 2'h1;
			end
		end

		if (cmd == CMD_RD) begin
			rdEmit      = 1'b1;
			rdCurBk     = pins.bank;
			rdCurAp     = pins.addr[AP_BIT];
			rdCol       = pins.addr[COL_W-1:0];
			s_d.rdStart = pins.addr[COL_W-1:0];
			s_d.rdBank  = pins.bank;
			s_d.rdAp    = pins.addr[AP_BIT];
			s_d.rdK     = COL_W'(1);
			s_d.rdAct   = (last != '0);
		end else if (cmd == CMD_WR || cmd == CMD_STOP) begin
			s_d.rdAct = 1'b0;
		end else if (s_q.rdAct) begin
			rdEmit  = 1'b1;
			rdCurK  = s_q.rdK;
			rdCurBk = s_q.rdBank;
			rdCurAp = s_q.rdAp;
			rdCol   = sbac_burst_col(s_q.rdStart, s_q.rdK, last, interleaved);
			s_d.rdK = s_q.rdK + 1'b1;
			if (s_q.rdK == last) begin
				s_d.rdAct = 1'b0;
			end
		end

		if (rdEmit && rdCurAp && ((last - rdCurK) <= clm1)) begin
			s_d.bankOpen[rdCurBk] = 1'b0;
		end

		if (cmd == CMD_WR) begin
			wrWord      = 1'b1;
			wrCurBk     = pins.bank;
			wrCurAp     = pins.addr[AP_BIT];
			wrStartNow  = pins.addr[COL_W-1:0];
			s_d.wrStart = pins.addr[COL_W-1:0];
			s_d.wrBank  = pins.bank;
			s_d.wrAp    = pins.addr[AP_BIT];
			s_d.wrK     = COL_W'(1);
			s_d.wrAct   = (last != '0);
		end else if (cmd == CMD_RD || cmd == CMD_STOP) begin
			s_d.wrAct = 1'b0;
		end else if (s_q.wrAct) begin
			wrWord     = 1'b1;
			wrCurK     = s_q.wrK;
			wrCurBk    = s_q.wrBank;
			wrCurAp    = s_q.wrAp;
			wrStartNow = s_q.wrStart;
			s_d.wrK    = s_q.wrK + 1'b1;
			if (s_q.wrK == last) begin
				s_d.wrAct = 1'b0;
			end
		end

		if (wrWord) begin
			pushValid     = !pins.dqm;
			pushData.bank = wrCurBk;
			pushData.col  = sbac_burst_col(wrStartNow, wrCurK, last, interleaved);
			pushData.data = dqIn;
		end

		if (wrWord && wrCurAp && wrCurK == last) begin
			s_d.wrApPend = 1'b1;
			s_d.wrApCnt  = WR_REC_CYC - 2'h1;
			s_d.wrApBank = wrCurBk;
		end

		// read pipeline: the stage feeding the pins follows the latency setting
		s_d.pipeV[0] = rdEmit;
		s_d.pipeD[0] = s_q.mem[sbac_mem_idx(rdCurBk, rdCol)];
		s_d.pipeV[1] = s_q.pipeV[0];
		s_d.pipeD[1] = s_q.pipeD[0];
		s_d.dqOe     = s_q.pipeV[pipeSel] && !s_q.dqmD;
		s_d.dqOut    = s_q.pipeD[pipeSel];
		s_d.dqmD     = pins.dqm;

		// single port array: reads win, the buffer drains in idle cycles
		popReady = !rdEmit;
		if (popValid && popReady) begin
			s_d.mem[sbac_mem_idx(popData.bank, popData.col)] = popData.data;
		end

		case (cmd)
			CMD_ACT: begin
				s_d.bankOpen[pins.bank] = 1'b1;
			end
			CMD_PRE: begin
				if (pins.addr[AP_BIT]) begin
					s_d.bankOpen = '0;
				end else begin
					s_d.bankOpen[pins.bank] = 1'b0;
				end
			end
			CMD_SREF: begin
				s_d.selfRef = 1'b1;
			end
			default: begin
			end
		endcase

		s_d.bufReady = pushReady;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign dqOut       = s_q.dqOut;
	assign dqOe        = s_q.dqOe;
	assign bankOpen    = s_q.bankOpen;
	assign selfRefresh = s_q.selfRef;
	assign bufReady    = s_q.bufReady;

	// checks on the driven behaviour
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	a_dqm_read_hiz : assert property (pins.dqm |-> ##2 !dqOe)
		else $error("output driven two cycles after mask");
	a_dqm_wr_block : assert property (pins.dqm |-> !pushValid)
		else $error("masked write word accepted");
	a_rd_latency : assert property ((cmd == CMD_RD) && casLatency == CL_TWO && !pins.dqm
		##1 casLatency == CL_TWO |-> ##1 dqOe)
		else $error("read data missing at latency two");
	a_rd_ends_wr : assert property (cmd == CMD_RD |-> !pushValid ##1 !s_q.wrAct)
		else $error("write continued after read");
	a_wr_restart : assert property ((cmd == CMD_WR) && last != '0 |=>
		s_q.wrAct && s_q.wrK == COL_W'(1) && s_q.wrStart == $past(pins.addr[COL_W-1:0]))
		else $error("write burst not restarted");
	a_stop_keeps : assert property ((cmd == CMD_STOP) |=> !s_q.rdAct && !s_q.wrAct
		&& (s_q.bankOpen == $past(s_q.bankOpen) || $past(s_q.wrApPend)))
		else $error("burst stop misbehaved");
	a_seq_wrap : assert property (pushValid && !interleaved |->
		((pushData.col & ~last) == (wrStartNow & ~last)))
		else $error("sequential burst carried past wrap");
	a_inter_col : assert property (pushValid && interleaved |->
		pushData.col == (wrStartNow ^ (wrCurK & last)))
		else $error("interleave column wrong");
	a_wr_ap_close : assert property (wrWord && wrCurAp && wrCurK == last && !pins.dqm
		##1 cmd != CMD_ACT ##1 cmd != CMD_ACT |=> !s_q.bankOpen[$past(wrCurBk, 3)])
		else $error("write precharge not two clocks after last word");
	a_pre_all : assert property ((cmd == CMD_PRE) && pins.addr[AP_BIT] |=> s_q.bankOpen == '0)
		else $error("precharge all left a bank open");
	a_sref_hold : assert property (s_q.selfRef && !pins.cke |=> s_q.selfRef)
		else $error("self refresh left while enable low");
	a_sref_exit : assert property (s_q.selfRef && pins.cke |=> !s_q.selfRef)
		else $error("self refresh not left on enable high");
	a_wr_idle : assert property (!s_q.wrAct && cmd != CMD_WR |-> !pushValid)
		else $error("data taken outside a write burst");

	c_read_burst : cover property ((cmd == CMD_RD) ##1 s_q.rdAct ##[1:4] dqOe);
	c_rd_rd : cover property (s_q.rdAct && (cmd == CMD_RD));
	c_wr_ap : cover property (s_q.wrApPend ##[1:3] !s_q.wrApPend);
	c_sref : cover property ((cmd == CMD_SREF) ##1 s_q.selfRef ##[1:8] !s_q.selfRef);

endmodule : sbac_top

//--- sbac_pkg.sv
// sbac_pkg: shared constants, pin carriers, command decode and burst address arithmetic
package sbac_pkg;

	localparam int DATA_W         = 16;
	localparam int COL_W          = 5;
	localparam int BANK_W         = 1;
	localparam int ADDR_W         = 11;
	localparam int NUM_BANKS      = 2 ** BANK_W;
	localparam int MEM_WORDS      = 2 ** (BANK_W + COL_W);
	localparam int AP_BIT         = 10;
	localparam int PIPE_STAGES    = 2;
	localparam int SBAC_FIFO_DEPTH = 32;
	localparam logic [1:0] WR_REC_CYC = 2'h2;
	localparam logic [1:0] CL_TWO     = 2'h2;

	// burst length codes as held in the mode setting
	localparam logic [2:0] BURST_COUNT_1    = 3'h0;
	localparam logic [2:0] BURST_COUNT_2    = 3'h1;
	localparam logic [2:0] BURST_COUNT_4    = 3'h2;
	localparam logic [2:0] BURST_COUNT_8    = 3'h3;
	localparam logic [2:0] BURST_COUNT_PAGE = 3'h7;

	typedef enum logic [2:0] {CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_STOP, CMD_SREF, CMD_OTHER} sbac_cmd_e;

	typedef struct packed {
		logic              csN;
		logic              rasN;
		logic              casN;
		logic              weN;
		logic              cke;
		logic              dqm;
		logic [BANK_W-1:0] bank;
		logic [ADDR_W-1:0] addr;
	} sbac_pins_s;

	typedef struct packed {
		logic [BANK_W-1:0] bank;
		logic [COL_W-1:0]  col;
		logic [DATA_W-1:0] data;
	} sbac_wr_s;

	typedef struct packed {
		logic [MEM_WORDS-1:0][DATA_W-1:0]   mem;
		logic [PIPE_STAGES-1:0]             pipeV;
		logic [PIPE_STAGES-1:0][DATA_W-1:0] pipeD;
		logic                               rdAct;
		logic                               rdAp;
		logic [BANK_W-1:0]                  rdBank;
		logic [COL_W-1:0]                   rdStart;
		logic [COL_W-1:0]                   rdK;
		logic                               wrAct;
		logic                               wrAp;
		logic [BANK_W-1:0]                  wrBank;
		logic [COL_W-1:0]                   wrStart;
		logic [COL_W-1:0]                   wrK;
		logic                               wrApPend;
		logic [1:0]                         wrApCnt;
		logic [BANK_W-1:0]                  wrApBank;
		logic [NUM_BANKS-1:0]               bankOpen;
		logic                               selfRef;
		logic                               dqmD;
		logic                               dqOe;
		logic [DATA_W-1:0]                  dqOut;
		logic                               bufReady;
	} sbac_state_s;

	// command decode from the strobes; clock enable low turns every command but self refresh entry into a no-op
	function automatic sbac_cmd_e sbac_decode(input sbac_pins_s p);
		sbac_cmd_e c;
		c = CMD_NOP;
		if (!p.csN) begin
			case ({p.rasN, p.casN, p.weN})
				3'h3: c = CMD_ACT;
				3'h5: c = CMD_RD;
				3'h4: c = CMD_WR;
				3'h2: c = CMD_PRE;
				3'h6: c = CMD_STOP;
				3'h1: c = p.cke ? CMD_OTHER : CMD_SREF;
				3'h7: c = CMD_NOP;
				default: c = CMD_OTHER;
			endcase
			if (!p.cke && c != CMD_SREF) begin
				c = CMD_NOP;
			end
		end
		return c;
	endfunction : sbac_decode

	// index of the last word of a burst, which is also the wrap mask
	function automatic logic [COL_W-1:0] sbac_len_last(input logic [2:0] code);
		logic [COL_W-1:0] m;
		case (code)
			BURST_COUNT_1:    m = COL_W'(0);
			BURST_COUNT_2:    m = COL_W'(1);
			BURST_COUNT_4:    m = COL_W'(3);
			BURST_COUNT_8:    m = COL_W'(7);
			BURST_COUNT_PAGE: m = '1;
			default: m = COL_W'(0);
		endcase
		return m;
	endfunction : sbac_len_last

	// column of burst word k; the wrap mask keeps carries out of the upper bits
	function automatic logic [COL_W-1:0] sbac_burst_col(input logic [COL_W-1:0] start,
		input logic [COL_W-1:0] k, input logic [COL_W-1:0] mask, input logic inter);
		logic [COL_W-1:0] sum;
		sum = start + k;
		return inter ? (start ^ (k & mask)) : ((start & ~mask) | (sum & mask));
	endfunction : sbac_burst_col

	function automatic logic [BANK_W+COL_W-1:0] sbac_mem_idx(input logic [BANK_W-1:0] b,
		input logic [COL_W-1:0] c);
		return {b, c};
	endfunction : sbac_mem_idx

endpackage : sbac_pkg

//--- sbac_fifo.sv
// sbac_fifo: parameterised flop FIFO with valid and ready on both sides
module sbac_fifo
	import sbac_pkg::*;
#(
	parameter int WIDTH = $bits(sbac_wr_s),
	parameter int DEPTH = SBAC_FIFO_DEPTH
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	input  wire logic             inValid,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  inReady,
	output logic                  outValid,
	output logic      [WIDTH-1:0] outData,
	input  wire logic             outReady
);

	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0]                 wp;
		logic [AW:0]                 rp;
	} sbac_fifo_st_s;

	sbac_fifo_st_s s_q;
	sbac_fifo_st_s s_d;
	logic          full;
	logic          empty;

	// pointer arithmetic needs a power of two depth
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
		$error("sbac_fifo depth must be a power of two of at least 2");
	end

	// extra pointer bit tells full from empty without a counter
	always_comb begin
		s_d      = s_q;
		full     = (s_q.wp[AW] != s_q.rp[AW]) && (s_q.wp[AW-1:0] == s_q.rp[AW-1:0]);
		empty    = (s_q.wp == s_q.rp);
		inReady  = !full;
		outValid = !empty;
		outData  = s_q.mem[s_q.rp[AW-1:0]];
		if (inValid && !full) begin
			s_d.mem[s_q.wp[AW-1:0]] = inData;
			s_d.wp                  = s_q.wp + 1'b1;
		end
		if (outReady && !empty) begin
			s_d.rp = s_q.rp + 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

endmodule : sbac_fifo

//--- sbac_host_model.sv
// sbac_host_model: behavioural memory controller driving the command and data pins
module sbac_host_model
	import sbac_pkg::*;
#(
	parameter int RCD_CYC = 2,
	parameter int RP_CYC  = 2,
	parameter int RC_CYC  = 4
) (
	input  wire logic              clk_sys,
	output sbac_pins_s             pins,
	output logic      [DATA_W-1:0] dqIn
);
	timeunit 1ns;
	timeprecision 1ps;

	// every other no-op slot becomes a deselect carrying write strobes, which the device must ignore
	logic desel = 1'h0;

	// idle pins at time zero, clock enabled
	initial begin
		pins = '{csN: 1'h1, rasN: 1'h1, casN: 1'h1, weN: 1'h1, cke: 1'h1, default: '0};
		dqIn = 16'h5A5A;
	end

	// one command per edge, changed just after the edge; strobes given as {ras,cas,we}
	task automatic issue(input logic [2:0] rcw, input logic [BANK_W-1:0] b, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, input logic m, input logic ck);
		logic hide;
		@(posedge clk_sys);
		hide  = (rcw == 3'h7) && !desel;
		desel = hide;
		pins  <= '{csN: hide, rasN: rcw[2], casN: rcw[1] & ~hide, weN: rcw[0] & ~hide, cke: ck, dqm: m, bank: b,
			addr: a};
		dqIn  <= d;
	endtask : issue

	// released data toggles
	// a floating bus must never look like a stale valid word
	task automatic cmd(input logic [2:0] rcw, input logic [BANK_W-1:0] b, input logic [ADDR_W-1:0] a,
		input logic m, input logic ck);
		issue(rcw, b, a, ~dqIn, m, ck);
	endtask : cmd

	task automatic stop();
		cmd(3'h6, 1'h0, 11'h000, 1'h0, 1'h1);
	endtask : stop

	// no-op slot with the byte mask raised
	task automatic mask();
		cmd(3'h7, 1'h0, 11'h000, 1'h1, 1'h1);
	endtask : mask

	task automatic idle(input int n);
		for (int i = 0; i < n; i++) begin
			cmd(3'h7, 1'h0, 11'h000, 1'h0, 1'h1);
		end
	endtask : idle

	task automatic act(input logic [BANK_W-1:0] b);
		cmd(3'h3, b, 11'h000, 1'h0, 1'h1);
		idle(RCD_CYC);
	endtask : act

	task automatic pre(input logic [BANK_W-1:0] b, input logic all);
		cmd(3'h2, b, {all, 10'h000}, 1'h0, 1'h1);
		idle(RP_CYC);
	endtask : pre

endmodule : sbac_host_model

//--- testbench.sv
// testbench: self-checking bench for the dram burst engine
module testbench
	import sbac_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int         LIMIT     = 10000;
	localparam logic [2:0] CODES [5] = '{BURST_COUNT_1, BURST_COUNT_2, BURST_COUNT_4, BURST_COUNT_8,
		BURST_COUNT_PAGE};

	logic                 clk_sys;
	logic                 rst_n;
	sbac_pins_s           pins;
	logic [DATA_W-1:0]    dqIn;
	logic [2:0]           burstLenCode;
	logic                 interleaved;
	logic [1:0]           casLatency;
	logic [DATA_W-1:0]    dqOut;
	logic                 dqOe;
	logic [NUM_BANKS-1:0] bankOpen;
	logic                 selfRefresh;
	logic                 bufReady;
	logic [DATA_W-1:0]    expMem [MEM_WORDS];
	logic [31:0]          capQ [$];
	logic [31:0]          expQ [$];
	int                   cyc;
	int                   fail_count;
	int                   check_count;
	int                   lw;
	int                   cl;

	sbac_top dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .pins(pins), .dqIn(dqIn), .burstLenCode(burstLenCode),
		.interleaved(interleaved), .casLatency(casLatency), .dqOut(dqOut), .dqOe(dqOe), .bankOpen(bankOpen),
		.selfRefresh(selfRefresh), .bufReady(bufReady));
	sbac_host_model host_u (.clk_sys(clk_sys), .pins(pins), .dqIn(dqIn));

	initial begin
		clk_sys = 1'h0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// capture driven read words with their edge; also the hang limit
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (dqOe === 1'h1) begin
			capQ.push_back({cyc[15:0], dqOut});
		end
		if (cyc >= LIMIT) begin
			fail_count++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		if (fail_count == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : give_verdict

	task automatic cmp(input logic [31:0] got, input logic [31:0] want);
		check_count++;
		if (got !== want) begin
			fail_count++;
			$display("ERROR %0t got %h expected %h", $time, got, want);
		end
	endtask : cmp

	// column of burst word k, worked out independently of the design
	function automatic logic [COL_W-1:0] colOf(input logic [COL_W-1:0] s, input int k);
		logic [COL_W-1:0] m;
		logic [COL_W-1:0] kk;
		m = COL_W'(lw - 1);
		kk = COL_W'(k);
		return interleaved ? (s ^ (kk & m)) : ((s & ~m) | ((s + kk) & m));
	endfunction : colOf

	// change mode only while the pins idle, else the last command repeats
	task automatic mode(input int i, input logic il, input int c);
		@(posedge clk_sys);
		burstLenCode <= CODES[i];
		interleaved <= il;
		casLatency <= 2'(c);
		lw = (i == 4) ? 32 : (1 << i);
		cl = c;
	endtask : mode

	task automatic wr(input logic [BANK_W-1:0] b, input logic [10:0] a, input int nw,
		input logic [DATA_W-1:0] base, input logic [31:0] mk);
		for (int k = 0; k < nw; k++) begin
			host_u.issue(k == 0 ? 3'h4 : 3'h7, b, a, base + DATA_W'(k), mk[k], 1'h1);
			if (!mk[k]) begin
				expMem[{b, colOf(a[COL_W-1:0], k)}] = base + DATA_W'(k);
			end
		end
	endtask : wr

	task automatic rd(input logic [BANK_W-1:0] b, input logic [10:0] a, input int nw, input logic m);
		host_u.cmd(3'h5, b, a, m, 1'h1);
		for (int k = 0; k < nw; k++) begin
			expQ.push_back({16'(cyc + 1 + cl + k), expMem[{b, colOf(a[COL_W-1:0], k)}]});
		end
	endtask : rd

	task automatic chk();
		host_u.idle(45);
		cmp(32'(capQ.size()), 32'(expQ.size()));
		while (expQ.size() > 0 && capQ.size() > 0) begin
			cmp(capQ.pop_front(), expQ.pop_front());
		end
		capQ.delete();
		expQ.delete();
	endtask : chk

	// whole bank read back in sequential page mode
	task automatic full(input logic [BANK_W-1:0] b);
		host_u.idle(8);
		mode(4, 1'h0, 2);
		rd(b, 11'h000, 32, 1'h0);
		chk();
	endtask : full

	task automatic t_modes();
		host_u.act(1'h0);
		for (int i = 4; i >= 0; i--) begin
			mode(i, i[0], 2 + i % 2);
			wr(1'h0, 11'(7 + 5 * i), lw, 16'(16'h1000 * (i + 1)), 32'h0);
			host_u.idle(8);
			rd(1'h0, 11'(7 + 5 * i), lw, 1'h0);
			chk();
		end
		full(1'h0);
	endtask : t_modes

	task automatic t_interrupt();
		host_u.act(1'h1);
		mode(2, 1'h0, 2);
		rd(1'h0, 11'h000, 1, 1'h0);
		rd(1'h0, 11'h010, 4, 1'h0);
		chk();
		wr(1'h0, 11'h000, 2, 16'hA000, 32'h0);
		wr(1'h0, 11'h008, 4, 16'hB000, 32'h0);
		wr(1'h0, 11'h018, 2, 16'hC000, 32'h0);
		rd(1'h1, 11'h000, 4, 1'h0);
		chk();
		rd(1'h0, 11'h004, 0, 1'h1);
		wr(1'h0, 11'h004, 4, 16'hD000, 32'h0);
		chk();
		rd(1'h0, 11'h000, 4, 1'h0);
		host_u.mask();
		expQ.delete(1);
		chk();
		wr(1'h0, 11'h010, 4, 16'hE000, 32'h2);
		full(1'h0);
	endtask : t_interrupt

	// burst stop only on a full page burst
	task automatic t_stop();
		rd(1'h0, 11'h000, 3, 1'h0);
		host_u.idle(2);
		host_u.stop();
		chk();
		cmp(32'(bankOpen[0]), 32'h1);
		wr(1'h0, 11'h01E, 3, 16'hF000, 32'h0);
		host_u.stop();
		full(1'h0);
	endtask : t_stop

	// auto-precharge bursts run uninterrupted and never in page mode
	task automatic t_autopre();
		mode(2, 1'h0, 2);
		rd(1'h1, 11'h400, 4, 1'h0);
		host_u.idle(2);
		#1 cmp(32'(bankOpen[1]), 32'h1);
		host_u.idle(1);
		#1 cmp(32'(bankOpen[1]), 32'h0);
		chk();
		host_u.act(1'h1);
		wr(1'h1, 11'h404, 4, 16'h7000, 32'h0);
		host_u.idle(2);
		#1 cmp(32'(bankOpen[1]), 32'h1);
		host_u.idle(1);
		#1 cmp(32'(bankOpen[1]), 32'h0);
		host_u.idle(6);
		host_u.act(1'h1);
		host_u.pre(1'h0, 1'h0);
		#1 cmp(32'(bankOpen), 32'h2);
		host_u.pre(1'h1, 1'h1);
		#1 cmp(32'(bankOpen), 32'h0);
	endtask : t_autopre

	task automatic t_sref();
		host_u.cmd(3'h1, 1'h0, 11'h000, 1'h0, 1'h0);
		repeat (3) host_u.cmd(3'h3, 1'h0, 11'h000, 1'h0, 1'h0);
		#1 cmp(32'({selfRefresh, bankOpen}), 32'h4);
		host_u.cmd(3'h3, 1'h0, 11'h000, 1'h0, 1'h1);
		host_u.idle(1);
		#1 cmp(32'({selfRefresh, bankOpen}), 32'h0);
		host_u.idle(host_u.RC_CYC);
		host_u.act(1'h0);
		#1 cmp(32'(bankOpen), 32'h1);
	endtask : t_sref

	// reset, then each scenario in turn
	initial begin
		rst_n = 1'h0;
		burstLenCode = BURST_COUNT_4;
		interleaved = 1'h0;
		casLatency = 2'h2;
		fail_count = 0;
		check_count = 0;
		lw = 4;
		cl = 2;
		foreach (expMem[i]) expMem[i] = '0;
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'h1;
		#1 cmp(32'({dqOe, bankOpen, selfRefresh}), 32'h0);
		host_u.idle(2);
		#1 cmp(32'(bufReady), 32'h1);
		t_modes();
		t_interrupt();
		t_stop();
		t_autopre();
		t_sref();
		give_verdict();
	end

endmodule : testbench
